// >>> lss_pkg.sv
// shared constants and carrier types for the linear sensor scan timing block
package lss_pkg;
  localparam int unsigned CORE_CLK_HZ = 100_000_000;
  localparam int unsigned PIX_CLK_MAX_HZ = 10_000_000;
  localparam int unsigned PIX_CLK_MIN_CORE_CYC = CORE_CLK_HZ / PIX_CLK_MAX_HZ;
  localparam int unsigned PIX_TOTAL = 4096;
  localparam int unsigned PIX_EFFECTIVE = 4008;
  localparam int unsigned PIX_REF_EACH_END = 20;
  localparam int unsigned INT_EXTRA_PCLK = 48;
  localparam int unsigned FIRST_VIDEO_STROBE = 89;
  localparam int unsigned PIX_W = 16;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned IDX_W = 12;
  localparam int unsigned CNT_W = 13;
  localparam logic [CNT_W-1:0] LAST_STROBE = CNT_W'(FIRST_VIDEO_STROBE + PIX_TOTAL - 1);
  localparam logic [CNT_W-1:0] VIDEO_START_CNT = CNT_W'(FIRST_VIDEO_STROBE - 1);
  localparam logic [IDX_W-1:0] REF_LOW_END = IDX_W'(PIX_REF_EACH_END);
  localparam logic [IDX_W-1:0] REF_HIGH_START = IDX_W'(PIX_REF_EACH_END + PIX_EFFECTIVE);
  localparam logic [6:0] INT_EXTRA_CNT = 7'(INT_EXTRA_PCLK);

  typedef enum logic [1:0] {LSS_IDLE, LSS_ARMED, LSS_SHIFT} lss_state_e;

  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic [IDX_W-1:0] index;
    logic reference;
    logic first_scan;
    logic underrun;
  } lss_video_s;
endpackage

// >>> lss_fifo.sv
// parameterised valid/ready fifo used in the pixel path
`timescale 1ns/1ps
module lss_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } lss_fifo_st_s;

  lss_fifo_st_s st_ff;
  lss_fifo_st_s nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_wr;
  logic do_rd;

  assign in_ready = st_ff.count != (AW+1)'(DEPTH);
  assign out_valid = st_ff.count != '0;
  assign out_data = mem[st_ff.rd_ptr];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (do_wr) begin
      nxt_st.wr_ptr = (st_ff.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_ff.wr_ptr + 1'b1;
    end
    if (do_rd) begin
      nxt_st.rd_ptr = (st_ff.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_ff.rd_ptr + 1'b1;
    end
    nxt_st.count = st_ff.count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // storage has no reset: contents only matter behind the pointers
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[st_ff.wr_ptr] <= in_data;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_fifo_no_overflow: assert property (st_ff.count <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
  a_fifo_count_track: assert property (do_wr && !do_rd |=> st_ff.count == $past(st_ff.count) + 1'b1)
    else $error("fifo count did not follow a write");
endmodule // lss_fifo

// >>> lss_scan_timing.sv
// scan timing generator and pixel readout sequencer of the linear sensor
//
// Contract
// - all readout timing comes from only the scan-begin pulse and pixel clock
// - pixel clock up to 10 MHz, one pixel delivered per pixel clock
// - line holds 4096 pixels: 20 reference each end, 4008 effective; the code tags the top 68 pixels (index 4028 up) as reference
// - all pixels integrate together over the same interval
// - integration lasts scan pulse high time plus 48 pixel clocks
// - shifting starts on first pixel clock rise after scan pulse falls
// - video is valid at the sample strobe rising edge
// - first video sample comes on strobe 89 after the falling edge
// - a digital sample strobe output marks when to capture video
`timescale 1ns/1ps
module lss_scan_timing (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pixel_clk,
  input wire logic scan_begin_pulse,
  input wire logic array_valid,
  output logic array_ready,
  input wire logic [lss_pkg::PIX_W-1:0] array_data,
  output logic integrating,
  output logic sample_strobe,
  output logic scan_active,
  output logic video_valid,
  output lss_pkg::lss_video_s video
);
  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    lss_pkg::lss_state_e state;
    logic pclk_q;
    logic sbp_q;
    logic [lss_pkg::CNT_W-1:0] strobe_cnt;
    logic [6:0] int_cnt;
    logic integrating;
    logic strobe;
    logic vvalid;
    logic first_scan;
    lss_pkg::lss_video_s video;
  } lss_st_s;

  lss_st_s st_ff;
  lss_st_s nxt_st;
  logic pclk_rise;
  logic sbp_fall;
  logic sbp_rise;
  logic fifo_valid;
  logic fifo_pop;
  logic [lss_pkg::PIX_W-1:0] fifo_data;
  logic [lss_pkg::CNT_W-1:0] cnt_inc;
  logic [lss_pkg::IDX_W-1:0] pix_idx;

  // --------------------------------------------------------------
  // pixel buffer between the array and the video output
  // --------------------------------------------------------------
  lss_fifo #(
    .WIDTH(lss_pkg::PIX_W),
    .DEPTH(lss_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(array_valid),
    .in_ready(array_ready),
    .in_data(array_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // --------------------------------------------------------------
  // edge detection on the two control inputs
  // --------------------------------------------------------------
  // inputs are synchronous to core_clk, so one register is enough for edges
  assign pclk_rise = pixel_clk & ~st_ff.pclk_q;
  assign sbp_fall = st_ff.sbp_q & ~scan_begin_pulse;
  assign sbp_rise = ~st_ff.sbp_q & scan_begin_pulse;
  assign cnt_inc = st_ff.strobe_cnt + 1'b1;
  assign pix_idx = lss_pkg::IDX_W'(cnt_inc - lss_pkg::CNT_W'(lss_pkg::FIRST_VIDEO_STROBE));
  // one pixel leaves the buffer on each strobe inside the video window
  assign fifo_pop = (st_ff.state == lss_pkg::LSS_SHIFT) && pclk_rise
                    && (st_ff.strobe_cnt >= lss_pkg::VIDEO_START_CNT);

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pclk_q = pixel_clk;
    nxt_st.sbp_q = scan_begin_pulse;
    // strobe follows the pixel clock while shifting: one strobe per pixel clock
    if (!pixel_clk) begin
      nxt_st.strobe = 1'b0;
    end
    // shared integration window for the whole line
    if (scan_begin_pulse) begin
      nxt_st.integrating = 1'b1;
      nxt_st.int_cnt = '0;
    end else if (st_ff.integrating && pclk_rise) begin
      nxt_st.int_cnt = st_ff.int_cnt + 1'b1;
      if (st_ff.int_cnt + 1'b1 == lss_pkg::INT_EXTRA_CNT) begin
        nxt_st.integrating = 1'b0;
      end
    end
    unique case (st_ff.state)
      lss_pkg::LSS_IDLE, lss_pkg::LSS_SHIFT: begin
        if (st_ff.state == lss_pkg::LSS_SHIFT && pclk_rise) begin
          nxt_st.strobe = 1'b1;
          nxt_st.strobe_cnt = cnt_inc;
          if (fifo_pop) begin
            nxt_st.vvalid = 1'b1;
            nxt_st.video.data = fifo_data;
            nxt_st.video.index = pix_idx;
            nxt_st.video.reference = (pix_idx < lss_pkg::REF_LOW_END)
                                     || (pix_idx >= lss_pkg::REF_HIGH_START);
            nxt_st.video.first_scan = st_ff.first_scan;
            nxt_st.video.underrun = ~fifo_valid;
          end
          if (cnt_inc == lss_pkg::LAST_STROBE) begin
            nxt_st.state = lss_pkg::LSS_IDLE;
            nxt_st.first_scan = 1'b0;
          end
        end
        // a new scan pulse abandons any readout still running
        if (sbp_rise) begin
          nxt_st.state = lss_pkg::LSS_IDLE;
        end
        if (sbp_fall) begin
          nxt_st.state = lss_pkg::LSS_ARMED;
        end
      end
      lss_pkg::LSS_ARMED: begin
        if (scan_begin_pulse) begin
          nxt_st.state = lss_pkg::LSS_IDLE;
        end else if (pclk_rise) begin
          nxt_st.state = lss_pkg::LSS_SHIFT;
          nxt_st.strobe = 1'b1;
          nxt_st.strobe_cnt = {{(lss_pkg::CNT_W-1){1'b0}}, 1'b1};
        end else begin
          nxt_st.strobe_cnt = '0;
        end
      end
    endcase
    // video window ends one core cycle after the strobe that carries the last pixel
    if (nxt_st.state != lss_pkg::LSS_SHIFT && !fifo_pop) begin
      nxt_st.vvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '{state: lss_pkg::LSS_IDLE, first_scan: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign integrating = st_ff.integrating;
  assign sample_strobe = st_ff.strobe;
  assign scan_active = st_ff.state == lss_pkg::LSS_SHIFT;
  assign video_valid = st_ff.vvalid;
  assign video = st_ff.video;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_armed_edge;
    st_ff.state == lss_pkg::LSS_ARMED && !scan_begin_pulse && pclk_rise;
  endsequence
  sequence s_first_strobe;
    sample_strobe && st_ff.strobe_cnt == 13'h0001;
  endsequence

  a_shift_on_edge: assert property (s_armed_edge |=> s_first_strobe)
    else $error("shift did not start on first pixel clock rise");
  a_int_hold_high: assert property (scan_begin_pulse |=> integrating)
    else $error("integration not active while scan pulse high");
  a_int_extra_end: assert property (integrating && !scan_begin_pulse && pclk_rise
                                    && st_ff.int_cnt == 7'h2f |=> !integrating)
    else $error("integration did not end after 48 pixel clocks");
  a_int_extra_hold: assert property ($fell(scan_begin_pulse) |=> integrating)
    else $error("integration ended at scan pulse fall");
  a_first_video_idx: assert property (pclk_rise && st_ff.state == lss_pkg::LSS_SHIFT
                                      && st_ff.strobe_cnt == 13'h0058
                                      |=> video_valid && video.index == 12'h000)
    else $error("first video sample not on strobe 89");
  a_no_early_video: assert property (scan_active && st_ff.strobe_cnt < 13'h0059
                                     && !$past(video_valid) |-> !video_valid)
    else $error("video before strobe 89");
  a_idx_in_order: assert property (pclk_rise && scan_active && video_valid
                                   && !sbp_rise && st_ff.strobe_cnt != lss_pkg::LAST_STROBE
                                   |=> video.index == $past(video.index) + 1'b1)
    else $error("pixel index out of order");
  a_strobe_with_clk: assert property (sample_strobe |-> $past(pixel_clk))
    else $error("strobe high while pixel clock low");
  a_strobe_one_clk: assert property ($rose(sample_strobe) |-> $past(pclk_rise))
    else $error("strobe rose without a pixel clock rise");
  // the shielded pixels sit at both ends, so both borders of the effective run are guarded
  a_ref_tag_low: assert property (video_valid && video.index < 12'h014 |-> video.reference)
    else $error("low reference pixel not tagged");
  a_ref_tag_eff: assert property (video_valid && video.index >= 12'h014 && video.index < lss_pkg::REF_HIGH_START
                                  |-> !video.reference)
    else $error("effective pixel tagged as reference");
  a_ref_tag_high: assert property (video_valid && video.index >= lss_pkg::REF_HIGH_START |-> video.reference)
    else $error("high reference pixel not tagged");
  a_data_at_strobe: assert property ($rose(sample_strobe) && video_valid
                                     |-> video.data == $past(fifo_data) || video.underrun)
    else $error("video data not presented with strobe");
endmodule // lss_scan_timing

// >>> lss_ctrl_model.sv
// acquisition controller model: pixel clock, scan pulse and video capture
`timescale 1ns/1ps
module lss_ctrl_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sample_strobe,
  input wire logic video_valid,
  input wire lss_pkg::lss_video_s video,
  output logic pixel_clk,
  output logic scan_begin_pulse
);
  localparam int LAST_VID = lss_pkg::FIRST_VIDEO_STROBE + lss_pkg::PIX_TOTAL - 1;
  localparam int REF_HI = lss_pkg::PIX_REF_EACH_END + lss_pkg::PIX_EFFECTIVE;
  logic [3:0] div_ff;
  logic strb_q = 1'b0;
  logic [15:0] exp_data = 16'h0000;
  logic first_fs = 1'b0;
  logic last_under = 1'b0;
  int strobes = 0;
  int first_vid = 0;
  int n_vid = 0;
  int bad = 0;

  // ------------------------------------------------------------
  // pixel clock and scan pulse
  // ------------------------------------------------------------
  // ten core cycles a period keeps the pixel clock at its 10 MHz ceiling
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= (div_ff == 4'h9) ? 4'h0 : div_ff + 4'h1;
    end
  end
  assign pixel_clk = (div_ff < 4'h5);

  initial scan_begin_pulse = 1'b0;

  // pulse edges land with the pixel clock fall, half a period away from pixel clock rises
  task automatic wait_mid(input int n);
    repeat (n) @(posedge core_clk iff div_ff == 4'h4);
  endtask

  task automatic scan(input int hi, input int lo);
    wait_mid(1);
    scan_begin_pulse <= 1'b1;
    wait_mid(hi);
    scan_begin_pulse <= 1'b0;
    wait_mid(lo);
    scan_begin_pulse <= 1'b1;
  endtask

  // ------------------------------------------------------------
  // video capture on the strobe rising edge
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (scan_begin_pulse) begin
      strobes = 0;
      n_vid = 0;
    end
    if (sample_strobe && !strb_q) begin
      strobes = strobes + 1;
      if (strobes <= LAST_VID && video_valid !== (strobes >= 89)) bad = bad + 1;
      if (video_valid === 1'b1) begin
        if (n_vid == 0) begin
          first_vid = strobes;
          first_fs = video.first_scan;
        end
        if (video.index !== n_vid[11:0]) bad = bad + 1;
        if (video.reference !== (n_vid < 20 || n_vid >= REF_HI)) bad = bad + 1;
        if (video.underrun === 1'b0) begin
          if (video.data !== exp_data) bad = bad + 1;
          exp_data = exp_data + 16'h0001;
        end
        last_under = video.underrun;
        n_vid = n_vid + 1;
      end
    end
    strb_q = sample_strobe;
  end
endmodule // lss_ctrl_model

// >>> lss_scan_timing_tb.sv
// self-checking testbench of the scan timing block
`timescale 1ns/1ps
module lss_scan_timing_tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic array_valid = 1'b0;
  logic [15:0] array_data = 16'h0000;
  logic pixel_clk, scan_begin_pulse, array_ready, integrating, sample_strobe, scan_active, video_valid;
  lss_pkg::lss_video_s video;
  logic pclk_q = 1'b0;
  int int_rises = 0;
  int fail_count = 0;
  int samples_checked = 0;

  // ------------------------------------------------------------
  // clock, instances, feed and watchdog
  // ------------------------------------------------------------
  initial forever #5 core_clk = ~core_clk;

  lss_scan_timing i_dut (.core_clk(core_clk), .rstn(rstn), .pixel_clk(pixel_clk),
    .scan_begin_pulse(scan_begin_pulse), .array_valid(array_valid), .array_ready(array_ready),
    .array_data(array_data), .integrating(integrating), .sample_strobe(sample_strobe),
    .scan_active(scan_active), .video_valid(video_valid), .video(video));

  lss_ctrl_model i_model (.core_clk(core_clk), .rstn(rstn), .sample_strobe(sample_strobe),
    .video_valid(video_valid), .video(video), .pixel_clk(pixel_clk), .scan_begin_pulse(scan_begin_pulse));

  // counting data lets the model check pixel order across scans
  always @(posedge core_clk) begin
    if (array_valid && array_ready) array_data <= array_data + 16'h0001;
    if (scan_begin_pulse) int_rises <= 0;
    else if (pixel_clk && !pclk_q && integrating === 1'b1) int_rises <= int_rises + 1;
    pclk_q <= pixel_clk;
  end

  initial begin
    #950_000;
    fail_count++;
    end_sim();
  end

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // empty fifo, minimum high time, then a new pulse cuts the readout short
  task automatic t_abort;
    i_model.scan(6, 100);
    check(i_model.first_vid, 89, "first video strobe");
    check(i_model.n_vid, 12, "pixels before abort");
    check(i_model.last_under, 1, "underrun with empty fifo");
    check(i_model.first_fs, 1, "first scan tag");
    repeat (20) @(posedge core_clk);
    check(scan_active, 0, "readout stopped");
    check(video_valid, 0, "video dropped");
    check(i_model.bad, 0, "video stream");
  endtask

  task automatic t_fill;
    array_valid <= 1'b1;
    repeat (20) @(posedge core_clk);
    check(array_ready, 0, "fifo full refuses");
  endtask

  // minimum high time, full line, integration length and scan tag
  task automatic t_scan(input logic fs);
    i_model.scan(6, 4190);
    check(int_rises, 48, "integration tail");
    check(i_model.first_vid, 89, "first video strobe");
    check(i_model.n_vid, 4096, "pixels per line");
    check(i_model.last_under, 0, "no underrun");
    check(i_model.first_fs, fs, "first scan tag");
    check(i_model.bad, 0, "video stream");
    repeat (3) @(posedge core_clk);
    check(integrating, 1, "shared integration");
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_abort();
    t_fill();
    t_scan(1'b1);
    t_scan(1'b0);
    end_sim();
  end
endmodule // lss_scan_timing_tb
